// *** pin_event_defines.svh ***
`ifndef PIN_EVENT_DEFINES_SVH
`define PIN_EVENT_DEFINES_SVH

// ==========================================================
// register offsets
`define OFS_CTRL_ONE      8'h92
`define OFS_CTRL_TWO      8'h97
`define OFS_TOP_STAT      8'h00
`define OFS_TOP_STAT_ALT  8'h02
`define OFS_LOW_STAT      8'h87
`define OFS_LOW_STAT_ALT  8'hF7
`define OFS_HIGH_STAT     8'h84
`define OFS_HIGH_STAT_ALT 8'hF4

// ==========================================================
// reset values
`define RST_CTRL_ONE      8'h00
`define RST_CTRL_TWO      8'h00

// ==========================================================
// status field positions
`define BIT_TOP_PIN_EVT   0
`define BIT_LOW_PIN2      7
`define BIT_LOW_PIN1      6
`define BIT_LOW_PIN0      5
`define BIT_LOW_LID_POS   4
`define BIT_LOW_LID_EVT   3
`define BIT_HIGH_PIN7     3
`define BIT_HIGH_PIN5     2
`define BIT_HIGH_PIN4     1
`define BIT_HIGH_PIN3     0

// ==========================================================
// timing
`define WARM_CYCLES       3'h4

`endif

// *** pin_event_pkg.sv ***
package pin_event_pkg;

   // ==========================================================
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   // ==========================================================
   // first control register layout
   typedef struct packed {
      logic       timer_fall;
      logic       lid_en;
      logic [2:0] fall_sel;
      logic [2:0] src_en;
   } ctrl_one_s;

   // ==========================================================
   // second control register layout
   typedef struct packed {
      logic       pin_seven_fall;
      logic [2:0] fall_sel;
      logic       pin_seven_en;
      logic [2:0] src_en;
   } ctrl_two_s;

endpackage

// *** pin_edge_event_control.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "pin_event_defines.svh"

// Functional notes
// [RQ1] both control registers reset to zero
// [RQ2] control one bit 7 picks pin seven edge reloading general timer two
// [RQ3] control one bit 6 turns pin six into the lid switch input
// [RQ4] lid mode: each pin six transition toggles lid status and interrupts
// [RQ5] lid event status sits at bit 3 of the 87h/F7h location
// [RQ6] lid mode: bit 4 of 87h/F7h shows current lid position
// [RQ7] control one bits 5..3 pick edges for pins 2..0, one is falling
// [RQ8] an edge select acts only with its enable bit set
// [RQ9] control one bits 2..0 enable pins 2..0 as interrupt sources
// [RQ10] every pin interrupt sets bit 0 of the 00h/02h top status
// [RQ11] pins 2..0 status at bits 7..5 of 87h/F7h
// [RQ12] software sets a pin as input before using its functions
// [RQ13] pin seven may interrupt and retrigger timer two, alone or together
// [RQ14] only pins 2..0 can wake the system with clocks stopped
// [RQ15] control two bit 7 picks pin seven edge, gated by bit 3
// [RQ16] control two bits 6..4 pick edges for pins 5..3, gated by bits 2..0
// [RQ17] control two bit 3 enables pin seven as interrupt source
// [RQ18] control two bits 2..0 enable pins 5..3 as interrupt sources
// [RQ19] pin seven status at bit 3 of 84h/F4h, pin five at bit 2
// [RQ20] pins are synchronised and edges found from consecutive samples

module pin_edge_event_control #(
   parameter int PIN_COUNT = 8
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     reset_n,
   // register port
   input  wire pin_event_pkg::reg_req_s  reg_req,
   output logic [7:0]                    reg_rdata,
   // pins and their direction, one means input
   input  wire logic [PIN_COUNT-1:0]     pin_in,
   input  wire logic [PIN_COUNT-1:0]     pin_input_mode,
   // power management context
   input  wire logic                     suspend_active,
   input  wire logic                     timer_retrigger_en,
   // event outputs
   output logic                          system_mgmt_interrupt,
   output logic                          timer_two_reload,
   output logic                          lid_switch_status,
   output logic                          wake_request
);

   // ==========================================================
   // control registers
   pin_event_pkg::ctrl_one_s ctrl_one_q;
   pin_event_pkg::ctrl_one_s ctrl_one_d;
   pin_event_pkg::ctrl_two_s ctrl_two_q;
   pin_event_pkg::ctrl_two_s ctrl_two_d;

   // ==========================================================
   // pin sampling
   logic [PIN_COUNT-1:0] sync1_q;
   logic [PIN_COUNT-1:0] sync2_q;
   logic [PIN_COUNT-1:0] sync3_q;
   logic [PIN_COUNT-1:0] level_q;
   logic [PIN_COUNT-1:0] prev_q;
   logic [2:0]           warm_q;
   logic                 armed_w;
   logic [PIN_COUNT-1:0] rise_w;
   logic [PIN_COUNT-1:0] fall_w;

   // ==========================================================
   // event qualification
   logic [PIN_COUNT-1:0] src_en_w;
   logic [PIN_COUNT-1:0] fall_sel_w;
   logic [PIN_COUNT-1:0] hit_w;
   logic                 lid_hit_w;
   logic                 any_hit_w;
   logic                 reload_hit_w;

   // ==========================================================
   // status
   logic                 top_q;
   logic                 top_d;
   logic [2:0]           low_pins_q;
   logic [2:0]           low_pins_d;
   logic                 lid_evt_q;
   logic                 lid_evt_d;
   logic [3:0]           high_pins_q;
   logic [3:0]           high_pins_d;
   logic                 lid_status_q;
   logic                 reload_q;
   logic                 wake_q;
   logic                 wake_set_a;

   // ==========================================================
   // register port decode
   logic       sel_ctrl_one_w;
   logic       sel_ctrl_two_w;
   logic       sel_top_w;
   logic       sel_top_alt_w;
   logic       sel_low_w;
   logic       sel_low_alt_w;
   logic       sel_high_w;
   logic       sel_high_alt_w;
   logic       clr_top_w;
   logic       clr_low_w;
   logic       clr_high_w;
   logic [7:0] top_view_w;
   logic [7:0] low_view_w;
   logic [7:0] high_view_w;
   logic [7:0] rd_val_w;
   logic [7:0] rdata_q;

   assign sel_ctrl_one_w = (reg_req.addr == `OFS_CTRL_ONE);
   assign sel_ctrl_two_w = (reg_req.addr == `OFS_CTRL_TWO);
   assign sel_top_w      = (reg_req.addr == `OFS_TOP_STAT);
   assign sel_top_alt_w  = (reg_req.addr == `OFS_TOP_STAT_ALT);
   assign sel_low_w      = (reg_req.addr == `OFS_LOW_STAT);
   assign sel_low_alt_w  = (reg_req.addr == `OFS_LOW_STAT_ALT);
   assign sel_high_w     = (reg_req.addr == `OFS_HIGH_STAT);
   assign sel_high_alt_w = (reg_req.addr == `OFS_HIGH_STAT_ALT);

   // the primary status offsets clear on read, the alternates only peek
   assign clr_top_w  = reg_req.rd & sel_top_w;
   assign clr_low_w  = reg_req.rd & sel_low_w;
   assign clr_high_w = reg_req.rd & sel_high_w;

   assign ctrl_one_d = (reg_req.wr && sel_ctrl_one_w) ?
                       pin_event_pkg::ctrl_one_s'(reg_req.wdata) : ctrl_one_q;
   assign ctrl_two_d = (reg_req.wr && sel_ctrl_two_w) ?
                       pin_event_pkg::ctrl_two_s'(reg_req.wdata) : ctrl_two_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_one_q <= pin_event_pkg::ctrl_one_s'(`RST_CTRL_ONE); // RQ1
         ctrl_two_q <= pin_event_pkg::ctrl_two_s'(`RST_CTRL_TWO); // RQ1
      end else begin
         ctrl_one_q <= ctrl_one_d;
         ctrl_two_q <= ctrl_two_d;
      end
   end

   // ==========================================================
   // pin synchronisers
   // a level is accepted only once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               sync3_q[gi] <= 1'b0;
               level_q[gi] <= 1'b0;
               prev_q[gi]  <= 1'b0;
            end else begin
               sync1_q[gi] <= pin_in[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               if (sync2_q[gi] == sync3_q[gi]) begin
                  level_q[gi] <= sync3_q[gi]; // RQ20
               end
               prev_q[gi] <= level_q[gi];
            end
         end
      end
   endgenerate

   // edges are masked for four cycles after reset; a pin already high at reset still shows one rising edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         warm_q <= 3'h0;
      end else if (!armed_w) begin
         warm_q <= warm_q + 3'h1;
      end
   end

   assign armed_w = (warm_q == `WARM_CYCLES);

   // outputs configured by software are masked out
   assign rise_w = level_q & ~prev_q & pin_input_mode & {PIN_COUNT{armed_w}}; // RQ20 RQ12
   assign fall_w = ~level_q & prev_q & pin_input_mode & {PIN_COUNT{armed_w}}; // RQ20 RQ12

   // ==========================================================
   // per pin edge selection and enable
   // pin six has no plain interrupt source; it only serves the lid
   assign src_en_w = {ctrl_two_q.pin_seven_en,                       // RQ17
                      1'b0,
                      ctrl_two_q.src_en,                             // RQ18
                      ctrl_one_q.src_en};                            // RQ9
   assign fall_sel_w = {ctrl_two_q.pin_seven_fall,                   // RQ15
                        1'b0,
                        ctrl_two_q.fall_sel,                         // RQ16
                        ctrl_one_q.fall_sel};                        // RQ7

   // the edge choice has no effect unless the enable is set
   assign hit_w = src_en_w & ((rise_w & ~fall_sel_w) | (fall_w & fall_sel_w)); // RQ8

   // lid mode reacts to both directions
   assign lid_hit_w = ctrl_one_q.lid_en & (rise_w[6] | fall_w[6]); // RQ3 RQ4

   assign any_hit_w = (|hit_w) | lid_hit_w; // RQ10

   // timer reload is independent of the pin seven interrupt enable
   assign reload_hit_w = timer_retrigger_en &
                         (ctrl_one_q.timer_fall ? fall_w[7] : rise_w[7]); // RQ2 RQ13

   // ==========================================================
   // sticky status, a new event beats a clear in the same cycle
   assign top_d       = (top_q & ~clr_top_w) | any_hit_w; // RQ10
   assign low_pins_d  = (low_pins_q & ~{3{clr_low_w}}) | hit_w[2:0]; // RQ11
   assign lid_evt_d   = (lid_evt_q & ~clr_low_w) | lid_hit_w; // RQ5
   assign high_pins_d = (high_pins_q & ~{4{clr_high_w}}) |
                        {hit_w[7], hit_w[5], hit_w[4], hit_w[3]}; // RQ19

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         top_q       <= 1'b0;
         low_pins_q  <= 3'h0;
         lid_evt_q   <= 1'b0;
         high_pins_q <= 4'h0;
      end else begin
         top_q       <= top_d;
         low_pins_q  <= low_pins_d;
         lid_evt_q   <= lid_evt_d;
         high_pins_q <= high_pins_d;
      end
   end

   // ==========================================================
   // lid status and timer reload
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lid_status_q <= 1'b0;
         reload_q     <= 1'b0;
      end else begin
         lid_status_q <= lid_status_q ^ lid_hit_w; // RQ4
         reload_q     <= reload_hit_w; // RQ2
      end
   end

   // ==========================================================
   // wake from suspend
   // with the clock stopped no sampler runs, so the selected level on an
   // enabled low pin sets the request asynchronously; a pin already sitting
   // at its active level when suspend begins wakes at once (limitation)
   assign wake_set_a = suspend_active &
                       (|(ctrl_one_q.src_en &
                          (pin_in[2:0] ^ ctrl_one_q.fall_sel))); // RQ14

   always_ff @(posedge core_clk or posedge wake_set_a or negedge reset_n) begin
      if (!reset_n) begin
         wake_q <= 1'b0;
      end else if (wake_set_a) begin
         wake_q <= 1'b1; // RQ14
      end else if (!suspend_active) begin
         wake_q <= 1'b0;
      end
   end

   // ==========================================================
   // read path
   assign top_view_w = 8'(top_q) << `BIT_TOP_PIN_EVT; // RQ10

   assign low_view_w = (8'(low_pins_q[2])                  << `BIT_LOW_PIN2)    | // RQ11
                       (8'(low_pins_q[1])                  << `BIT_LOW_PIN1)    |
                       (8'(low_pins_q[0])                  << `BIT_LOW_PIN0)    |
                       (8'(ctrl_one_q.lid_en & level_q[6]) << `BIT_LOW_LID_POS) | // RQ6
                       (8'(lid_evt_q)                      << `BIT_LOW_LID_EVT);  // RQ5

   assign high_view_w = (8'(high_pins_q[3]) << `BIT_HIGH_PIN7) | // RQ19
                        (8'(high_pins_q[2]) << `BIT_HIGH_PIN5) |
                        (8'(high_pins_q[1]) << `BIT_HIGH_PIN4) |
                        (8'(high_pins_q[0]) << `BIT_HIGH_PIN3);

   assign rd_val_w = sel_ctrl_one_w                  ? 8'(ctrl_one_q) :
                     sel_ctrl_two_w                  ? 8'(ctrl_two_q) :
                     (sel_top_w  || sel_top_alt_w)   ? top_view_w  :
                     (sel_low_w  || sel_low_alt_w)   ? low_view_w  :
                     (sel_high_w || sel_high_alt_w)  ? high_view_w :
                     8'h00;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_req.rd ? rd_val_w : 8'h00;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata             = rdata_q;
   assign system_mgmt_interrupt = top_q; // RQ10
   assign timer_two_reload      = reload_q;
   assign lid_switch_status     = lid_status_q;
   assign wake_request          = wake_q;

endmodule // pin_edge_event_control

// *** pin_source.sv ***
`timescale 1ns/1ps
// ==========================================================
// external pin drivers, levels change only when the bench asks
module pin_source (
   // pins
   output logic [7:0] pin_in,
   output logic [7:0] pin_input_mode
);
   initial begin
      pin_in         = 8'h00;
      pin_input_mode = 8'hFF;
   end
   task automatic set_pin(input int idx, input logic lvl);
      pin_in[idx] <= lvl;
   endtask
   // a pin turned to output must not raise events of its own
   task automatic set_mode(input int idx, input logic lvl);
      pin_input_mode[idx] <= lvl;
   endtask
endmodule // pin_source

// *** pin_event_sva.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checker
module pin_event_sva #(
   parameter int PIN_COUNT = 8
) (
   // clock and reset
   input wire logic                    core_clk,
   input wire logic                    reset_n,
   // register port
   input wire pin_event_pkg::reg_req_s reg_req,
   input wire logic [7:0]              reg_rdata,
   // pins and context
   input wire logic [PIN_COUNT-1:0]    pin_in,
   input wire logic [PIN_COUNT-1:0]    pin_input_mode,
   input wire logic                    suspend_active,
   input wire logic                    timer_retrigger_en,
   // events
   input wire logic                    system_mgmt_interrupt,
   input wire logic                    timer_two_reload,
   input wire logic                    lid_switch_status,
   input wire logic                    wake_request
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_reset_quiet:
      assert property ($rose(reset_n) |-> !system_mgmt_interrupt && !lid_switch_status
                       && !wake_request && !timer_two_reload) else $error("output set at reset");
   a_rdata_idle:
      assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00) else $error("stray read data");
   a_top_read:
      assert property (reg_req.rd && reg_req.addr == 8'h02 |=>
                       reg_rdata[0] == $past(system_mgmt_interrupt)) else $error("top status read");
   a_intr_sticky:
      assert property (system_mgmt_interrupt && !(reg_req.rd && reg_req.addr == 8'h00) |=>
                       system_mgmt_interrupt) else $error("interrupt dropped unread");
   a_lid_interrupt:
      assert property ($changed(lid_switch_status) |-> ##[0:1] system_mgmt_interrupt)
         else $error("lid toggle without interrupt");
   a_reload_pulse:
      assert property (timer_two_reload |=> !timer_two_reload) else $error("reload too long");
   a_reload_gate:
      assert property (!timer_retrigger_en [*8] |=> !timer_two_reload)
         else $error("reload while disabled");
   a_wake_clear:
      assert property ((!suspend_active ##1 !suspend_active) |-> !wake_request)
         else $error("wake outside suspend");
   a_quiet_pins:
      assert property (($stable(pin_in) && !system_mgmt_interrupt) [*8] |=>
                       !system_mgmt_interrupt) else $error("interrupt without pin edge");
endmodule // pin_event_sva

bind pin_edge_event_control pin_event_sva #(.PIN_COUNT(PIN_COUNT)) i_pin_event_sva (
   .core_clk, .reset_n, .reg_req, .reg_rdata, .pin_in, .pin_input_mode, .suspend_active,
   .timer_retrigger_en, .system_mgmt_interrupt, .timer_two_reload, .lid_switch_status,
   .wake_request);

// *** test_pin_edge_event_control.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_pin_edge_event_control;
   logic                     core_clk = 1'b0;
   logic                     reset_n  = 1'b0;
   pin_event_pkg::reg_req_s  req      = '0;
   logic [7:0]               reg_rdata;
   logic [7:0]               pin_in;
   logic [7:0]               pin_input_mode;
   logic                     suspend_active = 1'b0;
   logic                     timer_retrigger_en = 1'b0;
   logic                     system_mgmt_interrupt;
   logic                     timer_two_reload;
   logic                     lid_switch_status;
   logic                     wake_request;
   logic [7:0]               d;
   logic                     l0;
   int                       n_mismatch = 0;
   int                       compares = 0;
   int                       n_reload = 0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (timer_two_reload === 1'b1) n_reload++;
   pin_source i_pin_source (.pin_in(pin_in), .pin_input_mode(pin_input_mode));
   pin_edge_event_control #(.PIN_COUNT(8)) i_pin_edge_event_control (
      .core_clk(core_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_input_mode(pin_input_mode), .suspend_active(suspend_active),
      .timer_retrigger_en(timer_retrigger_en), .system_mgmt_interrupt(system_mgmt_interrupt),
      .timer_two_reload(timer_two_reload), .lid_switch_status(lid_switch_status),
      .wake_request(wake_request));
   // ==========================================================
   // bus and pin tasks
   task cyc(input int n); repeat (n) @(posedge core_clk); endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk) req <= '{a, v, 1'b1, 1'b0};
      @(posedge core_clk) req <= '0;
   endtask
   // data stand only in the cycle after the strobe, so sample just after that edge
   task rd(input logic [7:0] a);
      @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) req <= '0;
      #1 d = reg_rdata;
   endtask
   task drive(input int p, input logic v);
      @(posedge core_clk) i_pin_source.set_pin(p, v);
   endtask
   // wrong edge first, then the selected edge; status reads clear for the next case
   task edge_case(input logic [7:0] ca, input logic [7:0] cv, input int p, input logic post,
                  input logic [7:0] sa, input logic [7:0] exp);
      drive(p, post);
      cyc(8);
      rd(sa);
      rd(8'h00);
      wr(ca, cv);
      drive(p, !post);
      cyc(10);
      rd(sa); `CHK(d, 8'h00)
      drive(p, post);
      cyc(10);
      rd(sa); `CHK(d, exp)
      rd(8'h00); `CHK(d[0], |exp)
      wr(ca, 8'h00);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      final_report();
   end
   // ==========================================================
   // tests
   initial begin
      cyc(3);
      reset_n <= 1'b1;
      rd(8'h92); `CHK(d, 8'h00)
      rd(8'h97); `CHK(d, 8'h00)
      rd(8'h55); `CHK(d, 8'h00)
      wr(8'h97, 8'hA5);
      rd(8'h97); `CHK(d, 8'hA5)
      wr(8'h97, 8'h00);
      $display("register test done");
      for (int i = 0; i < 3; i++)
         for (int f = 0; f < 2; f++)
            edge_case(8'h92, 8'((f << (i + 3)) | (1 << i)), i, !f, 8'h87, 8'(8'h20 << i));
      for (int j = 0; j < 4; j++)
         for (int f = 0; f < 2; f++)
            edge_case(8'h97, 8'((f << (j + 4)) | (1 << j)), (j == 3) ? 7 : 3 + j, !f, 8'h84,
                      8'(8'h01 << j));
      edge_case(8'h92, 8'h08, 0, 1'b0, 8'h87, 8'h00);
      i_pin_source.set_mode(1, 1'b0);
      edge_case(8'h92, 8'h02, 1, 1'b1, 8'h87, 8'h00);
      i_pin_source.set_mode(1, 1'b1);
      $display("edge test done");
      wr(8'h92, 8'h40);
      l0 = lid_switch_status;
      drive(6, 1'b1);
      cyc(10);
      `CHK(lid_switch_status, !l0)
      `CHK(system_mgmt_interrupt, 1'b1)
      rd(8'hF7);
      `CHK(d, 8'h18)
      rd(8'h87); `CHK(d, 8'h18)
      rd(8'h02);
      `CHK(d[0], 1'b1)
      rd(8'h00); `CHK(d[0], 1'b1)
      `CHK(system_mgmt_interrupt, 1'b0)
      drive(6, 1'b0);
      cyc(10);
      `CHK(lid_switch_status, l0)
      rd(8'h87); `CHK(d, 8'h08)
      rd(8'h00);
      wr(8'h92, 8'h00);
      $display("lid test done");
      timer_retrigger_en <= 1'b1;
      wr(8'h92, 8'h80);
      drive(7, 1'b1);
      cyc(10);
      `CHK(n_reload, 0)
      drive(7, 1'b0);
      cyc(10);
      `CHK(n_reload, 1)
      rd(8'h84); `CHK(d, 8'h00)
      wr(8'h92, 8'h00);
      $display("timer test done");
      suspend_active <= 1'b1;
      wr(8'h97, 8'h01);
      drive(3, 1'b1);
      cyc(10);
      `CHK(wake_request, 1'b0)
      rd(8'hF4);
      `CHK(d, 8'h01)
      rd(8'h84);
      `CHK(d, 8'h01)
      rd(8'hF4);
      `CHK(d, 8'h00)
      wr(8'h92, 8'h01);
      drive(0, 1'b1);
      cyc(10);
      `CHK(wake_request, 1'b1)
      suspend_active <= 1'b0;
      cyc(3);
      `CHK(wake_request, 1'b0)
      $display("wake test done");
      final_report();
   end
endmodule // test_pin_edge_event_control
